/* File: verilog/iowd_top.sv */
module iowd_top #(
    parameter int P_TICK_CYCLES    = iowd_pkg::TICK_CYCLES,
    parameter int P_TIMEOUT_TICKS  = iowd_pkg::TIMEOUT_TICKS,
    parameter int P_RST_PULSE_CYC  = iowd_pkg::RST_PULSE_CYCLES
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_resetn,
    input  wire iowd_pkg::iowd_isa_s i_isa,
    input  wire logic                i_timeout_action_jumper,
    output logic [7:0]               o_sd,
    output logic                     o_sd_oe,
    output logic                     o_cpu_reset,
    output logic                     o_irq11
);

    logic                  rst_meta_r;
    logic                  rst_n_r;
    logic                  ior_prev_n_r;
    logic                  iow_prev_n_r;
    logic                  strap_taken_r;
    iowd_pkg::iowd_action_e action_r;
    iowd_pkg::iowd_state_e  state_r;
    logic                  first_read_done_r;
    logic                  restart;
    logic                  tick;
    logic                  timeout;
    logic                  pulse_done;
    logic                  rst_pulse_r;
    logic                  irq_r;
    logic                  port_hit;
    logic                  rd_start;
    logic                  wr_start;
    logic                  wr_refresh;
    logic                  wr_disable;
    logic                  rd_enable;
    logic                  armed;
    logic [7:0]            status;

    // Release of the asynchronous reset through two flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Jumper is a strap: caught once after reset release, never written by software
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            strap_taken_r <= 1'b0;
            action_r      <= iowd_pkg::ACT_RESET;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            action_r      <= iowd_pkg::iowd_action_e'(i_timeout_action_jumper);
        end
    end

    // Port decode on the leading edge of each strobe
    assign port_hit = (i_isa.addr == iowd_pkg::PORT_ADDR) && !i_isa.aen;

    // Strobe history idles high so reset release makes no false edge
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ior_prev_n_r <= 1'b1;
            iow_prev_n_r <= 1'b1;
        end else begin
            ior_prev_n_r <= i_isa.ior_n;
            iow_prev_n_r <= i_isa.iow_n;
        end
    end

    // Only the high-to-low step counts, so a long strobe acts once
    assign rd_start   = port_hit && ior_prev_n_r && !i_isa.ior_n;
    assign wr_start   = port_hit && iow_prev_n_r && !i_isa.iow_n;
    assign wr_refresh = wr_start && (i_isa.data == iowd_pkg::CMD_REFRESH);
    assign wr_disable = wr_start && (i_isa.data == iowd_pkg::CMD_DISABLE);
    assign rd_enable  = rd_start && !first_read_done_r;

    // Later reads only return status; re-enabling needs a write of one
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            first_read_done_r <= 1'b0;
        end else if (rd_start) begin
            first_read_done_r <= 1'b1;
        end
    end

    // Any enabling access restarts both prescaler and timeout count from zero
    assign restart = wr_refresh || rd_enable || wr_disable;
    assign armed   = (state_r == iowd_pkg::WD_ARMED);

    iowd_counter #(
        .LIMIT   (P_TICK_CYCLES)
    ) u_prescale (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n_r),
        .i_clear (restart),
        .i_run   (armed),
        .o_done  (tick)
    );

    // Nominal count only; oscillator and divider spread stays inside the margin
    iowd_counter #(
        .LIMIT   (P_TIMEOUT_TICKS)
    ) u_timeout (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n_r),
        .i_clear (restart),
        .i_run   (armed && tick),
        .o_done  (timeout)
    );

    // Watchdog state; a refresh, a disable or the first read in the same cycle as a timeout wins
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= iowd_pkg::WD_OFF;
        end else begin
            case (state_r)
                iowd_pkg::WD_OFF: begin
                    if (wr_refresh || rd_enable) begin
                        state_r <= iowd_pkg::WD_ARMED;
                    end
                end
                iowd_pkg::WD_ARMED: begin
                    if (wr_disable) begin
                        state_r <= iowd_pkg::WD_OFF;
                    end else if (wr_refresh || rd_enable) begin
                        state_r <= iowd_pkg::WD_ARMED;
                    end else if (timeout) begin
                        state_r <= iowd_pkg::WD_FIRED;
                    end
                end
                iowd_pkg::WD_FIRED: begin
                    if (wr_disable) begin
                        state_r <= iowd_pkg::WD_OFF;
                    end else if (wr_refresh || rd_enable) begin
                        state_r <= iowd_pkg::WD_ARMED;
                    end
                end
                default: begin
                    state_r <= iowd_pkg::WD_OFF;
                end
            endcase
        end
    end

    // Reset action: fixed-width pulse so the CPU sees a clean reset
    iowd_counter #(
        .LIMIT   (P_RST_PULSE_CYC)
    ) u_rst_pulse (
        .i_clk   (i_clk_sys),
        .i_rst_n (rst_n_r),
        .i_clear (!rst_pulse_r),
        .i_run   (rst_pulse_r),
        .o_done  (pulse_done)
    );

    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rst_pulse_r <= 1'b0;
        end else if (armed && timeout && !restart && action_r == iowd_pkg::ACT_RESET) begin
            rst_pulse_r <= 1'b1;
        end else if (pulse_done) begin
            rst_pulse_r <= 1'b0;
        end
    end

    // Interrupt action: level held until the host writes one or zero
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_r <= 1'b0;
        end else if (armed && timeout && !restart && action_r == iowd_pkg::ACT_IRQ) begin
            irq_r <= 1'b1;
        end else if (wr_refresh || wr_disable) begin
            irq_r <= 1'b0;
        end
    end

    // Status byte; spare bits read as zero
    always_comb begin
        status                             = iowd_pkg::STATUS_RESET;
        status[iowd_pkg::STAT_ENABLED_BIT] = armed;
        status[iowd_pkg::STAT_FIRED_BIT]   = (state_r == iowd_pkg::WD_FIRED);
        status[iowd_pkg::STAT_ACTION_BIT]  = action_r;
    end

    // Registered outputs; read data trails the strobe by one clock
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_sd        <= iowd_pkg::STATUS_RESET;
            o_sd_oe     <= 1'b0;
        end else begin
            o_sd        <= status;
            o_sd_oe     <= port_hit && !i_isa.ior_n;
        end
    end

    // Action pins retimed so no decode glitch reaches the CPU or the interrupt line
    always_ff @(posedge i_clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_cpu_reset <= 1'b0;
            o_irq11     <= 1'b0;
        end else begin
            o_cpu_reset <= rst_pulse_r;
            o_irq11     <= irq_r;
        end
    end

endmodule

/* File: verilog/iowd_pkg.sv */
package iowd_pkg;

    // Host-visible port, decoded on the low 16 address bits
    localparam logic [15:0] PORT_ADDR        = 16'h0443;
    localparam logic [7:0]  CMD_DISABLE      = 8'h00;
    localparam logic [7:0]  CMD_REFRESH      = 8'h01;

    // Read-back layout of the port
    localparam int          STAT_ENABLED_BIT = 0;
    localparam int          STAT_FIRED_BIT   = 1;
    localparam int          STAT_ACTION_BIT  = 2;

    // Timing, in their own units first
    localparam int          CLK_MHZ          = 40;
    localparam int          TICK_US          = 1000;
    localparam int          TIMEOUT_MS       = 1600;
    localparam int          TOLERANCE_PCT    = 30;
    localparam int          RST_PULSE_US     = 100;

    // Derived cycle and tick counts
    localparam int          TICK_CYCLES      = TICK_US * CLK_MHZ;
    localparam int          TIMEOUT_TICKS    = (TIMEOUT_MS * 1000) / TICK_US;
    localparam int          RST_PULSE_CYCLES = RST_PULSE_US * CLK_MHZ;

    // Reset value of the port read-back
    localparam logic [7:0]  STATUS_RESET     = 8'h00;

    typedef struct packed {
        logic [15:0] addr;
        logic        aen;
        logic        ior_n;
        logic        iow_n;
        logic [7:0]  data;
    } iowd_isa_s;

    typedef enum logic [1:0] {
        WD_OFF   = 2'b00,
        WD_ARMED = 2'b01,
        WD_FIRED = 2'b10
    } iowd_state_e;

    typedef enum logic {
        ACT_RESET = 1'b0,
        ACT_IRQ   = 1'b1
    } iowd_action_e;

endpackage

/* File: verilog/iowd_counter.sv */
module iowd_counter #(
    parameter int LIMIT = 2
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    input  wire logic i_run,
    output logic      o_done
);

    localparam int W = (LIMIT > 1) ? $clog2(LIMIT) : 1;
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] count_r;

    // Clear dominates so a restart always begins from zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_r <= '0;
        end else if (i_clear) begin
            count_r <= '0;
        end else if (i_run) begin
            count_r <= (count_r == LAST) ? '0 : count_r + W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_clear && i_run && (count_r == LAST);
        end
    end

endmodule

/* File: test/iowd_props.sv */
module iowd_props #(
    parameter int P_TICK_CYCLES   = iowd_pkg::TICK_CYCLES,
    parameter int P_TIMEOUT_TICKS = iowd_pkg::TIMEOUT_TICKS,
    parameter int P_RST_PULSE_CYC = iowd_pkg::RST_PULSE_CYCLES
) (
    input wire logic                i_clk_sys,
    input wire logic                i_resetn,
    input wire iowd_pkg::iowd_isa_s i_isa,
    input wire logic                i_timeout_action_jumper,
    input wire logic [7:0]          o_sd,
    input wire logic                o_sd_oe,
    input wire logic                o_cpu_reset,
    input wire logic                o_irq11
);
    timeunit 1ns;
    timeprecision 1ps;
    // Window allows the tolerance plus a few cycles of pipeline
    localparam int NOM = P_TICK_CYCLES * P_TIMEOUT_TICKS;
    localparam int LO  = NOM * 7 / 10;
    localparam int HI  = NOM * 13 / 10 + 4;
    logic        pr_r;
    logic        pw_r;
    logic        seen_r;
    int unsigned cyc_r;
    int unsigned hi_r;
    wire hit  = i_isa.addr == iowd_pkg::PORT_ADDR && !i_isa.aen;
    wire rd_e = hit && !i_isa.ior_n && pr_r;
    wire wr_e = hit && !i_isa.iow_n && pw_r;
    wire kick = (wr_e && i_isa.data == iowd_pkg::CMD_REFRESH) || (rd_e && !seen_r);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pr_r   <= 1'b1;
            pw_r   <= 1'b1;
            seen_r <= 1'b0;
            cyc_r  <= 0;
            hi_r   <= 0;
        end else begin
            pr_r   <= i_isa.ior_n;
            pw_r   <= i_isa.iow_n;
            seen_r <= seen_r | rd_e;
            cyc_r  <= kick ? 0 : cyc_r + 1;
            hi_r   <= o_cpu_reset ? hi_r + 1 : 0;
        end
    end
    sequence s_kick;
        kick;
    endsequence
    sequence s_off;
        wr_e && i_isa.data == iowd_pkg::CMD_DISABLE;
    endsequence
    AST_KICK_ARMS: assert property (s_kick |-> ##2 o_sd[1:0] == 2'b01)
        else $error("port access did not arm");
    AST_ZERO_DISARMS: assert property (s_off |-> ##2 o_sd[1:0] == 2'b00)
        else $error("zero write did not disarm");
    AST_ZERO_QUIETS: assert property (s_off |-> ##2 !o_irq11 [*8])
        else $error("interrupt after zero write");
    AST_FIRE_WINDOW: assert property ($rose(o_sd[1]) |-> cyc_r inside {[LO:HI]})
        else $error("timeout outside window");
    AST_ARMED_BOUND: assert property (o_sd[0] |-> cyc_r <= HI)
        else $error("armed too long");
    AST_IRQ_MODE: assert property (o_irq11 |-> o_sd[2] && !o_cpu_reset)
        else $error("interrupt in reset mode");
    AST_RST_MODE: assert property (o_cpu_reset |-> !o_sd[2])
        else $error("cpu reset in interrupt mode");
    AST_ACT_CAUSE: assert property (($rose(o_irq11) || $rose(o_cpu_reset))
        |-> o_sd[1] || $past(o_sd[1]))
        else $error("action without timeout");
    AST_PULSE_LEN: assert property ($fell(o_cpu_reset)
        |-> hi_r inside {[P_RST_PULSE_CYC:P_RST_PULSE_CYC + 1]})
        else $error("cpu reset pulse length");
    AST_IRQ_HOLD: assert property ($fell(o_irq11) |-> $past(wr_e, 2))
        else $error("interrupt dropped without write");
    AST_OE_TRACKS: assert property (1'b1 |=> o_sd_oe == $past(hit && !i_isa.ior_n))
        else $error("read enable mistimed");
endmodule

bind iowd_top iowd_props #(
    .P_TICK_CYCLES  (P_TICK_CYCLES),
    .P_TIMEOUT_TICKS(P_TIMEOUT_TICKS),
    .P_RST_PULSE_CYC(P_RST_PULSE_CYC)
) iowd_props_inst (
    .i_clk_sys              (i_clk_sys),
    .i_resetn               (i_resetn),
    .i_isa                  (i_isa),
    .i_timeout_action_jumper(i_timeout_action_jumper),
    .o_sd                   (o_sd),
    .o_sd_oe                (o_sd_oe),
    .o_cpu_reset            (o_cpu_reset),
    .o_irq11                (o_irq11)
);

/* File: test/iowd_host.sv */
module iowd_host (
    input  wire logic          i_clk,
    input  wire logic [7:0]    i_sd,
    output iowd_pkg::iowd_isa_s o_isa
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_isa = '{16'hffff, 1'b0, 1'b1, 1'b1, 8'hff};
    // Strobe held three edges; answer is registered one cycle late
    task automatic io(input logic [15:0] a, input logic aen, input logic wr,
                      input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        o_isa <= '{a, aen, wr, !wr, d};
        repeat (2) @(posedge i_clk);
        q = i_sd;
        @(posedge i_clk);
        // Released bus shows the inverse, not stale values
        o_isa <= '{~a, 1'b0, 1'b1, 1'b1, ~d};
    endtask
endmodule

/* File: test/iowd_top_test.sv */
module iowd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] a;
        logic        aen;
        logic [7:0]  d;
        logic [7:0]  st;
    } iowd_row_s;
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                jmp = 1'b1;
    iowd_pkg::iowd_isa_s isa;
    logic [7:0]          sd;
    logic [7:0]          q;
    logic                oe;
    logic                crst;
    logic                irq;
    int                  err_total = 0;
    int                  cmp_count = 0;
    int                  n;
    iowd_row_s           rows [6] = '{
        '{16'h0443, 1'b0, 8'h05, 8'h04},
        '{16'h0442, 1'b0, 8'h01, 8'h04},
        '{16'h0443, 1'b1, 8'h01, 8'h04},
        '{16'h0443, 1'b0, 8'h01, 8'h05},
        '{16'h0443, 1'b0, 8'h00, 8'h04},
        '{16'h0443, 1'b0, 8'h01, 8'h05}};
    always #12.5 clk = ~clk;
    iowd_top #(.P_TICK_CYCLES(4), .P_TIMEOUT_TICKS(5), .P_RST_PULSE_CYC(3)) iowd_top_inst (
        .i_clk_sys(clk), .i_resetn(rstn), .i_isa(isa), .i_timeout_action_jumper(jmp),
        .o_sd(sd), .o_sd_oe(oe), .o_cpu_reset(crst), .o_irq11(irq));
    iowd_host iowd_host_inst (.i_clk(clk), .i_sd(sd), .o_isa(isa));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic io(input logic wr, input logic [7:0] d);
        iowd_host_inst.io(iowd_pkg::PORT_ADDR, 1'b0, wr, d, q);
        @(posedge clk);
    endtask
    task automatic rst(input logic j);
        @(posedge clk);
        rstn <= 1'b0;
        jmp  <= j;
        repeat (3) @(posedge clk);
        chk(sd, iowd_pkg::STATUS_RESET);
        chk({5'h00, oe, crst, irq}, 8'h00);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    // Bounded wait for the chosen timeout action
    task automatic wait_act(input logic want_irq);
        n = 0;
        while ((want_irq ? irq : crst) !== 1'b1) begin
            @(posedge clk);
            n++;
            if (n > 200) begin
                err_total++;
                end_of_test();
            end
        end
    endtask
    initial begin
        rst(1'b1);
        foreach (rows[i]) begin
            iowd_host_inst.io(rows[i].a, rows[i].aen, 1'b1, rows[i].d, q);
            @(posedge clk);
            chk(sd, rows[i].st);
        end
        repeat (4) begin
            repeat (10) @(posedge clk);
            io(1'b1, 8'h01);
        end
        chk({7'h00, irq}, 8'h00);
        wait_act(1'b1);
        chk(8'(n inside {[14:30]}), 8'h01);
        chk({crst, sd[6:0]}, 8'h06);
        repeat (20) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        io(1'b1, 8'h01);
        chk({irq, sd[6:0]}, 8'h05);
        io(1'b1, 8'h00);
        repeat (40) @(posedge clk);
        chk({3'h0, irq, crst, sd[2:0]}, 8'h04);
        rst(1'b0);
        io(1'b0, 8'h00);
        chk(q, 8'h00);
        chk(sd, 8'h01);
        chk({7'h00, oe}, 8'h01);
        wait_act(1'b0);
        chk({irq, sd[6:0]}, 8'h02);
        repeat (8) @(posedge clk);
        io(1'b0, 8'h00);
        @(posedge clk);
        chk({crst, sd[6:0]}, 8'h02);
        chk(q, 8'h02);
        end_of_test();
    end
endmodule
